// ### design/irqfe_pkg.sv
// Constants and types for the interrupt request pin front end.
// Assumes a single 200 MHz clock domain and an AXI4-Lite register bus.
package irqfe_pkg;
   localparam int unsigned NLINES      = 4;
   localparam logic [7:0]  NMI_VECTOR  = 8'h02;
   localparam logic [7:0]  VEC_BASE    = 8'h0c;
   localparam logic [7:0]  SLAVE_VEC   = 8'h20;
   localparam logic [3:0]  ADDR_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_MASK   = 4'h4;
   localparam logic [3:0]  ADDR_STAT   = 4'h8;
   localparam logic [3:0]  ADDR_PEND   = 4'hc;
   localparam int unsigned C_EDGE_LSB  = 0;
   localparam int unsigned C_ACK2_BIT  = 4;
   localparam int unsigned C_ACK3_BIT  = 5;
   localparam int unsigned C_SLAVE_BIT = 6;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic [4:0]  MASK_RESET  = 5'h00;
   localparam int unsigned ST_NMI_BIT  = 4;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   localparam int unsigned ACK_CYCLES  = 2;
   typedef enum logic [1:0] {
      IRQFE_IDLE = 2'b00,
      IRQFE_NMI  = 2'b01,
      IRQFE_ACK  = 2'b10
   } irqfe_state_t;
endpackage

// ### design/irqfe_sync.sv
// Two-flop synchronizer with edge output for one request pin.
// Assumes the pin is sampled on aclk only.
`timescale 1ns/1ps
`default_nettype none
module irqfe_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end
   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
endmodule
`default_nettype wire

// ### design/irqfe_axil.sv
// AXI4-Lite slave for the front end's four registers.
// Assumes one write and one read in flight at a time.
`timescale 1ns/1ps
`default_nettype none
module irqfe_axil (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wr_en,
   output logic [3:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   output logic             rd_en,
   output logic [3:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_ok,
   input  wire logic        wr_ok
);
   logic        aw_have_r;
   logic        w_have_r;
   logic [3:0]  aw_r;
   logic [31:0] wd_r;
   logic [3:0]  ws_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire do_wr   = aw_have_r & w_have_r & ~bvalid_r;
   assign s_axi_awready = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready  = ~w_have_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign wr_en   = do_wr;
   assign wr_addr = aw_r;
   assign wr_data = wd_r;
   assign wr_strb = ws_r;
   assign rd_en   = ar_take;
   assign rd_addr = s_axi_araddr;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_r      <= 4'h0;
         wd_r      <= 32'h0000_0000;
         ws_r      <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= irqfe_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_have_r <= 1'b1;
            aw_r      <= s_axi_awaddr;
         end
         if (w_take) begin
            w_have_r <= 1'b1;
            wd_r     <= s_axi_wdata;
            ws_r     <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_ok ? irqfe_pkg::RESP_OKAY : irqfe_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= irqfe_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_ok ? rd_data : 32'h0000_0000;
         rresp_r  <= rd_ok ? irqfe_pkg::RESP_OKAY : irqfe_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### design/irqfe_top.sv
// Interrupt request pin front end: synchronizers, latches, vector handoff.
// Assumes the core pulses instr_boundary between instructions and core_ack
// when it takes the offered vector. Pins are sampled on aclk.
`timescale 1ns/1ps
`default_nettype none
module irqfe_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        nmi_pin,
   input  wire logic        maskable_line_0,
   input  wire logic        maskable_line_1,
   input  wire logic        maskable_line_2_or_ack_0_in,
   output logic             maskable_line_2_or_ack_0_out,
   output logic             maskable_line_2_or_ack_0_oe,
   input  wire logic        maskable_line_3_or_ack_1_in,
   output logic             maskable_line_3_or_ack_1_out,
   output logic             maskable_line_3_or_ack_1_oe,
   input  wire logic        instr_boundary,
   input  wire logic        core_ack,
   output logic             irq_req,
   output logic [7:0]       irq_vector,
   output logic             irq,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam int unsigned N = irqfe_pkg::NLINES;
   logic [31:0]             ctrl_r;
   logic [4:0]              mask_r;
   logic [4:0]              stat_r;
   logic [4:0]              stat_nxt;
   logic [N-1:0]            pend_r;
   logic [N-1:0]            pend_nxt;
   logic                    nmi_pend_r;
   irqfe_pkg::irqfe_state_t state_r;
   irqfe_pkg::irqfe_state_t state_nxt;
   logic [7:0]              vec_r;
   logic [N-1:0]            serv_r;
   logic                    ack_cnt_r;
   logic                    ack_line_r;
   logic [N-1:0]            raw;
   logic [N-1:0]            lvl;
   logic [N-1:0]            rise;
   logic                    nmi_lvl;
   logic                    nmi_rise;
   logic                    wr_en;
   logic [3:0]              wr_addr;
   logic [31:0]             wr_data;
   logic [3:0]              wr_strb;
   logic                    rd_en;
   logic [3:0]              rd_addr;
   logic [31:0]             rd_data;
   wire [N-1:0] edge_mode = ctrl_r[irqfe_pkg::C_EDGE_LSB +: N];
   wire         ack2_mode = ctrl_r[irqfe_pkg::C_ACK2_BIT];
   wire         ack3_mode = ctrl_r[irqfe_pkg::C_ACK3_BIT];
   wire         slave     = ctrl_r[irqfe_pkg::C_SLAVE_BIT];

   // Lowest-numbered pending line wins
   function automatic logic [N-1:0] first_one(input logic [N-1:0] v);
      logic [N-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction
   function automatic logic [7:0] line_vec(input logic [N-1:0] onehot);
      logic [7:0] r;
      r = irqfe_pkg::VEC_BASE;
      for (int i = 0; i < N; i++) begin
         if (onehot[i]) begin
            r = irqfe_pkg::VEC_BASE + 8'(i);
         end
      end
      return r;
   endfunction

   // In slave mode only line 0 requests; lines 2/3 acting as acks never request
   wire [N-1:0] in_ok = slave ? 4'h1 : {~ack3_mode, ~ack2_mode, 2'b11};
   assign raw = {maskable_line_3_or_ack_1_in, maskable_line_2_or_ack_0_in, maskable_line_1, maskable_line_0};
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gsync
         irqfe_sync u_sync (
            .aclk    (aclk),
            .aresetn (aresetn),
            .pin     (raw[g]),
            .level   (lvl[g]),
            .rise    (rise[g])
         );
      end
   endgenerate
   irqfe_sync u_nmi (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (nmi_pin),
      .level   (nmi_lvl),
      .rise    (nmi_rise)
   );

   wire [N-1:0] line_evt = (edge_mode & rise | ~edge_mode & lvl) & in_ok;
   wire [N-1:0] eligible = pend_r & ~mask_r[N-1:0];
   wire [N-1:0] pick     = first_one(eligible);
   wire         take     = (state_r == irqfe_pkg::IRQFE_IDLE) & instr_boundary;
   wire         take_nmi = take & nmi_pend_r;
   wire         take_int = take & ~nmi_pend_r & (|eligible);
   wire         done     = (state_r != irqfe_pkg::IRQFE_IDLE) & core_ack;
   wire         rd_stat  = rd_en & (rd_addr == irqfe_pkg::ADDR_STAT);

   // Level lines drop their latch when the pin falls, even if not yet served
   always_comb begin
      pend_nxt = pend_r;
      pend_nxt = pend_nxt & (edge_mode | lvl);
      if (take_int) begin
         pend_nxt = pend_nxt & ~pick;
      end
      pend_nxt = pend_nxt | line_evt; // set wins over clear
   end
   always_comb begin
      stat_nxt = stat_r;
      if (rd_stat) begin
         stat_nxt = 5'h00;
      end
      stat_nxt = stat_nxt | {nmi_rise, line_evt & (edge_mode | ~pend_r)};
   end
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         irqfe_pkg::IRQFE_IDLE: begin
            if (take_nmi) begin
               state_nxt = irqfe_pkg::IRQFE_NMI;
            end else if (take_int) begin
               state_nxt = irqfe_pkg::IRQFE_ACK;
            end
         end
         irqfe_pkg::IRQFE_NMI: begin
            if (core_ack) begin
               state_nxt = irqfe_pkg::IRQFE_IDLE;
            end
         end
         irqfe_pkg::IRQFE_ACK: begin
            if (core_ack) begin
               state_nxt = irqfe_pkg::IRQFE_IDLE;
            end
         end
         default: state_nxt = irqfe_pkg::IRQFE_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= irqfe_pkg::IRQFE_IDLE;
         pend_r     <= '0;
         nmi_pend_r <= 1'b0;
         stat_r     <= 5'h00;
         vec_r      <= 8'h00;
         serv_r     <= '0;
      end else begin
         state_r <= state_nxt;
         pend_r  <= pend_nxt;
         stat_r  <= stat_nxt;
         // Latch survives until taken; a new edge during take re-arms it
         nmi_pend_r <= nmi_rise | (nmi_pend_r & ~take_nmi);
         if (take_nmi) begin
            vec_r <= irqfe_pkg::NMI_VECTOR;
         end else if (take_int) begin
            vec_r  <= slave ? irqfe_pkg::SLAVE_VEC : line_vec(pick);
            serv_r <= pick;
         end
         if (done) begin
            serv_r <= '0;
         end
      end
   end

   // Acknowledge strobe: two cycles low on the pin serving the taken line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack_cnt_r  <= 1'b0;
         ack_line_r <= 1'b0;
      end else if (done && (state_r == irqfe_pkg::IRQFE_ACK)) begin
         ack_cnt_r  <= 1'b1;
         ack_line_r <= serv_r[1];
      end else begin
         ack_cnt_r <= 1'b0;
      end
   end
   wire ack_active = done & (state_r == irqfe_pkg::IRQFE_ACK) | ack_cnt_r;
   wire ack_sel1   = ack_cnt_r ? ack_line_r : serv_r[1];
   // Ack pins pair with lines 0 and 1 in master mode
   assign maskable_line_2_or_ack_0_oe  = ack2_mode & ~slave;
   assign maskable_line_3_or_ack_1_oe  = ack3_mode & ~slave;
   assign maskable_line_2_or_ack_0_out = ~(ack_active & ~ack_sel1);
   assign maskable_line_3_or_ack_1_out = ~(ack_active & ack_sel1);

   assign irq_req    = (state_r != irqfe_pkg::IRQFE_IDLE);
   assign irq_vector = vec_r;
   assign irq        = |(stat_r & ~mask_r);

   // Register file; the non-maskable bit of mask is hard zero
   wire ctrl_hit = wr_en & (wr_addr == irqfe_pkg::ADDR_CTRL);
   wire mask_hit = wr_en & (wr_addr == irqfe_pkg::ADDR_MASK);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= irqfe_pkg::CTRL_RESET;
         mask_r <= irqfe_pkg::MASK_RESET;
      end else begin
         if (ctrl_hit && wr_strb[0]) begin
            ctrl_r <= {25'h0, wr_data[6:0]};
         end
         if (mask_hit && wr_strb[0]) begin
            mask_r <= {1'b0, wr_data[3:0]};
         end
      end
   end
   wire wr_ok = (wr_addr == irqfe_pkg::ADDR_CTRL) | (wr_addr == irqfe_pkg::ADDR_MASK);
   wire rd_ok = 1'b1;
   assign rd_data = (rd_addr == irqfe_pkg::ADDR_CTRL) ? ctrl_r :
                    (rd_addr == irqfe_pkg::ADDR_MASK) ? {27'h0, mask_r} :
                    (rd_addr == irqfe_pkg::ADDR_STAT) ? {27'h0, stat_r} :
                    {23'h0, nmi_pend_r, irq_req, 3'h0, pend_r};

   irqfe_axil u_axil (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_ok         (rd_ok),
      .wr_ok         (wr_ok)
   );

   property p_nmi_vec;
      @(posedge aclk) disable iff (!aresetn) take_nmi |=> irq_vector == irqfe_pkg::NMI_VECTOR && irq_req;
   endproperty
   a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong");
   sequence s_nmi_edge;
      !nmi_pin ##1 nmi_pin;
   endsequence
   property p_nmi_latch;
      @(posedge aclk) disable iff (!aresetn) s_nmi_edge |-> ##3 nmi_pend_r;
   endproperty
   a_nmi_latch: assert property (p_nmi_latch) else $error("nmi edge not latched");
   property p_nmi_nomask;
      @(posedge aclk) disable iff (!aresetn) nmi_pend_r && take |=> state_r == irqfe_pkg::IRQFE_NMI;
   endproperty
   a_nmi_nomask: assert property (p_nmi_nomask) else $error("nmi not taken");
   property p_mask_nmi_zero;
      @(posedge aclk) disable iff (!aresetn) mask_r[irqfe_pkg::ST_NMI_BIT] == 1'b0;
   endproperty
   a_mask_nmi_zero: assert property (p_mask_nmi_zero) else $error("nmi maskable");
   property p_sync_delay;
      @(posedge aclk) disable iff (!aresetn) lvl[0] == $past(maskable_line_0, 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong");
   property p_edge_set;
      @(posedge aclk) disable iff (!aresetn) edge_mode[0] && in_ok[0] && rise[0] |=> pend_r[0];
   endproperty
   a_edge_set: assert property (p_edge_set) else $error("edge not pended");
   property p_level_drop;
      @(posedge aclk) disable iff (!aresetn) !edge_mode[1] && !lvl[1] |=> !pend_r[1];
   endproperty
   a_level_drop: assert property (p_level_drop) else $error("level latch stuck");
   property p_ack_oe;
      @(posedge aclk) disable iff (!aresetn) maskable_line_2_or_ack_0_oe |-> ack2_mode && !slave;
   endproperty
   a_ack_oe: assert property (p_ack_oe) else $error("ack pin driven wrongly");
   property p_ack_pulse;
      @(posedge aclk) disable iff (!aresetn)
         done && state_r == irqfe_pkg::IRQFE_ACK |-> (ack_active [*2]) ##1 !ack_active;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack strobe length");
   property p_reset_clear;
      @(posedge aclk) !aresetn |=> pend_r == '0 && !nmi_pend_r && !irq_req;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left state");
endmodule
`default_nettype wire

// ### sim/irqfe_src_model.sv
// Model of the external request sources behind the pins.
// Assumes bench commands are one-cycle pulses launched after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module irqfe_src_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [3:0] raise,
   input  wire logic [3:0] drop,
   input  wire logic       nmi_go,
   output logic [3:0]      lines,
   output logic            nmi
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lines <= 4'h0;
         nmi   <= 1'b0;
      end else begin
         lines <= (lines | raise) & ~drop;
         nmi   <= nmi_go;
      end
   end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the request pin front end.
// Assumes the designer's register map and vector choices.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        aclk = 0, aresetn = 0, nmi_go = 0, nmi, bnd = 0, cack = 0;
   logic [3:0]  raise = 0, drop = 0, src, awaddr = 0, araddr = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        o2, e2, o3, e3, irq_req, irq, awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 0, rdata, rd;
   logic [1:0]  bresp, rresp, rs, ack_low;
   logic [7:0]  vec;
   int          miscompares = 0, compares = 0, cyc = 0, l;

   always #2.5 aclk = ~aclk;

   irqfe_src_model src_m (.aclk(aclk), .aresetn(aresetn), .raise(raise), .drop(drop), .nmi_go(nmi_go),
      .lines(src), .nmi(nmi));

   // Pin wire: device wins while it drives
   irqfe_top uut (.aclk(aclk), .aresetn(aresetn), .nmi_pin(nmi), .maskable_line_0(src[0]),
      .maskable_line_1(src[1]), .maskable_line_2_or_ack_0_in(e2 ? o2 : src[2]),
      .maskable_line_2_or_ack_0_out(o2), .maskable_line_2_or_ack_0_oe(e2),
      .maskable_line_3_or_ack_1_in(e3 ? o3 : src[3]), .maskable_line_3_or_ack_1_out(o3),
      .maskable_line_3_or_ack_1_oe(e3), .instr_boundary(bnd), .core_ack(cack), .irq_req(irq_req),
      .irq_vector(vec), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   task give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         give_verdict;
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1;
      wvalid  <= 1;
      bready  <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      rs = bresp;
      bready <= 0;
      @(posedge aclk);
   endtask

   task rdr(input logic [3:0] a);
      araddr  <= a;
      arvalid <= 1;
      rready  <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rd = rdata;
      chk(rresp, irqfe_pkg::RESP_OKAY, "read response");
      rready <= 0;
      @(posedge aclk);
   endtask

   task pins(input logic [3:0] r, input logic [3:0] d, input logic n);
      raise  <= r;
      drop   <= d;
      nmi_go <= n;
      @(posedge aclk);
      raise  <= 0;
      drop   <= 0;
      nmi_go <= 0;
      repeat (6) @(posedge aclk);
   endtask

   // Boundary pulse, then expect one offered vector and its acknowledge
   task serve(input logic [7:0] ev);
      int k;
      k = 0;
      bnd <= 1;
      @(posedge aclk);
      bnd <= 0;
      while (!irq_req && k < 20) begin
         @(posedge aclk);
         k++;
      end
      chk(irq_req, 1, "no request");
      chk(vec, ev, "vector");
      cack <= 1;
      ack_low = 0;
      repeat (3) begin
         @(posedge aclk);
         cack <= 0;
         if (!o2) ack_low[0] = 1'b1;
         if (!o3) ack_low[1] = 1'b1;
      end
      chk(irq_req, 0, "request not withdrawn");
   endtask

   task quiet;
      bnd <= 1;
      @(posedge aclk);
      bnd <= 0;
      repeat (10) @(posedge aclk);
      chk(irq_req, 0, "unexpected request");
   endtask

   task do_reset;
      aresetn <= 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
   endtask

   initial begin
      void'($urandom(69903));
      do_reset;
      for (int a = 0; a < 4; a++) begin
         rdr(4'(a * 4));
         chk(rd, 0, "register after reset");
      end
      chk({irq, irq_req, e2, e3, o2, o3}, 6'b000011, "idle outputs");
      wr(irqfe_pkg::ADDR_CTRL, 32'h0f);
      chk(rs, irqfe_pkg::RESP_OKAY, "write response");
      for (int n = 0; n < 4; n++) begin
         pins(4'(1 << n), 0, 0);
         serve(irqfe_pkg::VEC_BASE + 8'(n));
         chk(irq, 1, "irq after event");
         pins(0, 4'(1 << n), 0);
         rdr(irqfe_pkg::ADDR_STAT);
         chk(rd, 32'(1 << n), "status bit");
         chk(irq, 0, "irq after status read");
      end
      // Level mode recurs while held, stops once released
      wr(irqfe_pkg::ADDR_CTRL, 32'h0e);
      pins(4'h1, 0, 0);
      serve(irqfe_pkg::VEC_BASE);
      repeat (4) @(posedge aclk);
      serve(irqfe_pkg::VEC_BASE);
      pins(0, 4'h1, 0);
      quiet;
      // Everything masked: the non-maskable request still wins
      wr(irqfe_pkg::ADDR_CTRL, 32'h0f);
      wr(irqfe_pkg::ADDR_MASK, 32'h1f);
      rdr(irqfe_pkg::ADDR_MASK);
      chk(rd, 32'h0f, "mask readback");
      l = $urandom % 4;
      pins(4'(1 << l), 0, 1);
      serve(irqfe_pkg::NMI_VECTOR);
      rdr(irqfe_pkg::ADDR_STAT);
      chk(rd, 32'h11 | 32'(1 << l), "status with nmi");
      rdr(irqfe_pkg::ADDR_PEND);
      chk(rd, 32'(1 << l), "masked line pending");
      wr(irqfe_pkg::ADDR_MASK, 32'h0);
      serve(irqfe_pkg::VEC_BASE + 8'(l));
      pins(0, 4'hf, 0);
      // Line 2 turned into acknowledge output
      wr(irqfe_pkg::ADDR_CTRL, 32'h1f);
      chk({e2, e3}, 2'b10, "ack output enable");
      pins(4'h5, 0, 0);
      serve(irqfe_pkg::VEC_BASE);
      chk(ack_low, 1, "ack strobe");
      quiet;
      pins(0, 4'hf, 0);
      // Both acknowledge outputs; line 1 strobes the second one only
      wr(irqfe_pkg::ADDR_CTRL, 32'h3f);
      chk({e2, e3}, 2'b11, "both ack enables");
      pins(4'h2, 0, 0);
      serve(irqfe_pkg::VEC_BASE + 8'h01);
      chk(ack_low, 2, "ack 1 strobe");
      pins(0, 4'hf, 0);
      // Subordinate mode
      wr(irqfe_pkg::ADDR_CTRL, 32'h7f);
      chk({e2, e3}, 2'b00, "slave pin roles");
      pins(4'h2, 0, 0);
      quiet;
      pins(4'h1, 0, 0);
      serve(irqfe_pkg::SLAVE_VEC);
      pins(0, 4'hf, 0);
      wr(irqfe_pkg::ADDR_PEND, 32'h1);
      chk(rs, irqfe_pkg::RESP_SLVERR, "read-only write");
      wr(4'h3, 32'h1);
      chk(rs, irqfe_pkg::RESP_SLVERR, "unmapped write");
      // Reset in mid-run drops a pending masked request
      wr(irqfe_pkg::ADDR_CTRL, 32'h0f);
      wr(irqfe_pkg::ADDR_MASK, 32'h08);
      pins(4'h8, 0, 0);
      do_reset;
      rdr(irqfe_pkg::ADDR_PEND);
      chk(rd, 0, "pending after reset");
      rdr(irqfe_pkg::ADDR_CTRL);
      chk(rd, irqfe_pkg::CTRL_RESET, "control after reset");
      give_verdict;
   end
endmodule
`default_nettype wire
